// ---- rtl/loop_param_pkg.sv ----
// Package for the motor regulation-loop parameter register bank.
// Assumes a byte-wide register access port driven by the serial-bus front end.
package loop_param_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFF_INVERSE_RESISTANCE  = 8'h14;
  localparam logic [7:0] OFF_BACK_EMF_CONSTANT   = 8'h15;
  localparam logic [7:0] OFF_RESERVED_READONLY_A = 8'h16;
  localparam logic [7:0] OFF_RESERVED_RW_B       = 8'h17;
  localparam logic [7:0] OFF_PROPORTIONAL_GAIN   = 8'h18;
  localparam logic [7:0] OFF_INTEGRAL_GAIN       = 8'h19;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_INVERSE_RESISTANCE = 8'h00;
  localparam logic [7:0] RST_BACK_EMF_CONSTANT  = 8'h00;
  localparam logic [7:0] RST_RESERVED_RW_B      = 8'h00;
  localparam logic [7:0] RST_PROPORTIONAL_GAIN  = 8'h21;
  localparam logic [7:0] RST_INTEGRAL_GAIN      = 8'h21;
  localparam logic [7:0] RESERVED_READ_VALUE    = 8'h00;

  // ****************************************
  // Gain register field layout
  // ****************************************
  localparam int unsigned DIV_CODE_MSB = 7;
  localparam int unsigned DIV_CODE_LSB = 5;
  localparam int unsigned MULT_MSB     = 4;
  localparam int unsigned MULT_LSB     = 0;
  localparam int unsigned DIV_CODE_W   = 3;
  localparam int unsigned MULT_W       = 5;

  // Divisors are powers of two; the loop shifts by log2 of the divisor.
  localparam int unsigned SHIFT_W = 4;
  localparam logic [2:0] DIV_CODE_RESERVED = 3'h7;
  localparam logic [3:0] SHIFT_DIV_32   = 4'h5;
  localparam logic [3:0] SHIFT_DIV_64   = 4'h6;
  localparam logic [3:0] SHIFT_DIV_128  = 4'h7;
  localparam logic [3:0] SHIFT_DIV_256  = 4'h8;
  localparam logic [3:0] SHIFT_DIV_512  = 4'h9;
  localparam logic [3:0] SHIFT_DIV_16   = 4'h4;
  localparam logic [3:0] SHIFT_DIV_1    = 4'h0;

  // Resistance scale factors selected by the 2-bit selector.
  localparam int unsigned SCALE_W = 14;
  localparam logic [13:0] RES_SCALE_0 = 14'h0002;
  localparam logic [13:0] RES_SCALE_1 = 14'h0040;
  localparam logic [13:0] RES_SCALE_2 = 14'h0400;
  localparam logic [13:0] RES_SCALE_3 = 14'h2000;

endpackage

// ---- rtl/gain_divisor_decode.sv ----
// Decodes a gain divider code into a right-shift amount for the PI loop.
// Assumes its code input is a registered field on the same clock.
`timescale 1ns/1ns
`default_nettype none

module gain_divisor_decode (
  input  wire logic [2:0] divisor_code_i,
  output logic      [3:0] shift_o,
  output logic            code_reserved_o
);

  always_comb begin
    code_reserved_o = 1'b0;
    unique case (divisor_code_i)
      3'h0: shift_o = loop_param_pkg::SHIFT_DIV_32;   // RL4
      3'h1: shift_o = loop_param_pkg::SHIFT_DIV_64;
      3'h2: shift_o = loop_param_pkg::SHIFT_DIV_128;
      3'h3: shift_o = loop_param_pkg::SHIFT_DIV_256;
      3'h4: shift_o = loop_param_pkg::SHIFT_DIV_512;
      3'h5: shift_o = loop_param_pkg::SHIFT_DIV_16;
      3'h6: shift_o = loop_param_pkg::SHIFT_DIV_1;
      // No divisor exists for this code; hold the largest divisor so the gain stays small.
      3'h7: begin
        shift_o         = loop_param_pkg::SHIFT_DIV_512; // RL11
        code_reserved_o = 1'b1;                           // RL11
      end
    endcase
  end

endmodule

`default_nettype wire

// ---- rtl/motor_loop_param_regs.sv ----
// Register bank holding the regulation-loop parameters of a brushed DC motor driver.
// Assumes a byte-wide access port from the serial-bus front end on core_clk_i:
// a one-cycle write strobe with address and data, and a read address answered next cycle.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// RL1 - Inverse resistance register: 8-bit read/write, resets to zero.
// RL2 - Software must program a nonzero inverse resistance before relying on regulation.
// RL3 - Back-EMF constant at 0x15: 8-bit read/write, resets to zero.
// RL4 - Proportional divider code bits 7:5 select 32,64,128,256,512,16,1.
// RL5 - Proportional multiplier bits 4:0; gain equals multiplier over divisor.
// RL6 - Integral divider code bits 7:5 select 32,64,128,256,512,16,1.
// RL7 - Integral multiplier bits 4:0; gain equals multiplier over divisor.
// RL8 - Proportional gain register at 0x18 resets to 0x21.
// RL9 - Integral gain register at 0x19 resets to 0x21.
// RL10 - Resistance scale selector codes map to 2, 64, 1024 and 8192.
// RL11 - Divider code 7 is reserved and flagged; no divisor defined.
// RL12 - 0x16 ignores writes, reads zero; 0x17 stores writes, no effect.
module motor_loop_param_regs (
  input  wire logic       core_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       reg_wr_en_i,
  input  wire logic [7:0] reg_wr_addr_i,
  input  wire logic [7:0] reg_wr_data_i,
  input  wire logic       reg_rd_en_i,
  input  wire logic [7:0] reg_rd_addr_i,
  input  wire logic [1:0] resistance_scale_sel_i,
  output logic      [7:0] reg_rd_data_o,
  output logic            reg_rd_hit_o,
  output logic      [7:0] inverse_coil_resistance_o,
  output logic      [7:0] back_emf_value_o,
  output logic      [4:0] proportional_multiplier_o,
  output logic      [3:0] proportional_shift_o,
  output logic      [4:0] integral_multiplier_o,
  output logic      [3:0] integral_shift_o,
  output logic      [13:0] resistance_scale_factor_o,
  output logic            gain_code_reserved_o,
  output logic            inverse_resistance_zero_o
);

  // ****************************************
  // Parameter storage
  // ****************************************
  logic [7:0] inv_res_q;
  logic [7:0] back_emf_q;
  logic [7:0] reserved_field_b_q;
  logic [7:0] prop_gain_q;
  logic [7:0] int_gain_q;

  logic       wr_inv;
  logic       wr_emf;
  logic       wr_reserved_field_b;
  logic       wr_prop;
  logic       wr_int;

  assign wr_inv    = reg_wr_en_i && (reg_wr_addr_i == loop_param_pkg::OFF_INVERSE_RESISTANCE);
  assign wr_emf    = reg_wr_en_i && (reg_wr_addr_i == loop_param_pkg::OFF_BACK_EMF_CONSTANT);
  assign wr_reserved_field_b = reg_wr_en_i && (reg_wr_addr_i == loop_param_pkg::OFF_RESERVED_RW_B);
  assign wr_prop   = reg_wr_en_i && (reg_wr_addr_i == loop_param_pkg::OFF_PROPORTIONAL_GAIN);
  assign wr_int    = reg_wr_en_i && (reg_wr_addr_i == loop_param_pkg::OFF_INTEGRAL_GAIN);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      inv_res_q <= loop_param_pkg::RST_INVERSE_RESISTANCE; // RL1
    end else if (wr_inv) begin
      inv_res_q <= reg_wr_data_i; // RL1
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      back_emf_q <= loop_param_pkg::RST_BACK_EMF_CONSTANT; // RL3
    end else if (wr_emf) begin
      back_emf_q <= reg_wr_data_i; // RL3
    end
  end

  // The second reserved location keeps its value only so software can read it back.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      reserved_field_b_q <= loop_param_pkg::RST_RESERVED_RW_B; // RL12
    end else if (wr_reserved_field_b) begin
      reserved_field_b_q <= reg_wr_data_i; // RL12
    end
  end

  // Code 7 is stored as written so a read-back shows what software did.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      prop_gain_q <= loop_param_pkg::RST_PROPORTIONAL_GAIN; // RL8
    end else if (wr_prop) begin
      prop_gain_q <= reg_wr_data_i; // RL4 RL5
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      int_gain_q <= loop_param_pkg::RST_INTEGRAL_GAIN; // RL9
    end else if (wr_int) begin
      int_gain_q <= reg_wr_data_i; // RL6 RL7
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  logic [7:0] rd_data_d;
  logic       rd_hit_d;

  always_comb begin
    rd_hit_d  = 1'b1;
    rd_data_d = 8'h00;
    unique case (reg_rd_addr_i)
      loop_param_pkg::OFF_INVERSE_RESISTANCE:  rd_data_d = inv_res_q;
      loop_param_pkg::OFF_BACK_EMF_CONSTANT:   rd_data_d = back_emf_q;
      loop_param_pkg::OFF_RESERVED_READONLY_A: begin
        rd_data_d = loop_param_pkg::RESERVED_READ_VALUE; // RL12
      end
      loop_param_pkg::OFF_RESERVED_RW_B:       rd_data_d = reserved_field_b_q;
      loop_param_pkg::OFF_PROPORTIONAL_GAIN:   rd_data_d = prop_gain_q;
      loop_param_pkg::OFF_INTEGRAL_GAIN:       rd_data_d = int_gain_q;
      default: begin
        rd_hit_d  = 1'b0;
        rd_data_d = 8'h00;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      reg_rd_data_o <= 8'h00;
      reg_rd_hit_o  <= 1'b0;
    end else if (reg_rd_en_i) begin
      reg_rd_data_o <= rd_data_d;
      reg_rd_hit_o  <= rd_hit_d;
    end
  end

  // ****************************************
  // Loop parameter outputs
  // ****************************************
  logic [3:0]  prop_shift_d;
  logic [3:0]  int_shift_d;
  logic        prop_reserved_field_d;
  logic        int_reserved_field_d;
  logic [13:0] scale_d;

  gain_divisor_decode u_prop_div (
    .divisor_code_i  (prop_gain_q[loop_param_pkg::DIV_CODE_MSB:loop_param_pkg::DIV_CODE_LSB]),
    .shift_o         (prop_shift_d),
    .code_reserved_o (prop_reserved_field_d)
  );

  gain_divisor_decode u_int_div (
    .divisor_code_i  (int_gain_q[loop_param_pkg::DIV_CODE_MSB:loop_param_pkg::DIV_CODE_LSB]),
    .shift_o         (int_shift_d),
    .code_reserved_o (int_reserved_field_d)
  );

  always_comb begin
    unique case (resistance_scale_sel_i)
      2'h0: scale_d = loop_param_pkg::RES_SCALE_0; // RL10
      2'h1: scale_d = loop_param_pkg::RES_SCALE_1; // RL10
      2'h2: scale_d = loop_param_pkg::RES_SCALE_2; // RL10
      2'h3: scale_d = loop_param_pkg::RES_SCALE_3; // RL10
    endcase
  end

  // ****************************************
  // Registered copies for the regulation loop
  // ****************************************
  // Outputs are registered, so the loop sees a new value one cycle after the write lands.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      inverse_coil_resistance_o <= loop_param_pkg::RST_INVERSE_RESISTANCE; // RL1
    end else begin
      inverse_coil_resistance_o <= inv_res_q; // RL1
    end
  end

  // Regulation math divides by nothing here, but a zero value makes the loop useless.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      inverse_resistance_zero_o <= 1'b1;
    end else begin
      inverse_resistance_zero_o <= (inv_res_q == 8'h00); // RL2
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      back_emf_value_o <= loop_param_pkg::RST_BACK_EMF_CONSTANT; // RL3
    end else begin
      back_emf_value_o <= back_emf_q; // RL3
    end
  end

  // The reset shift matches the divider code held in each gain register's reset value.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      proportional_multiplier_o <=
        loop_param_pkg::RST_PROPORTIONAL_GAIN[loop_param_pkg::MULT_MSB:loop_param_pkg::MULT_LSB];
      proportional_shift_o      <= loop_param_pkg::SHIFT_DIV_64; // RL8
    end else begin
      proportional_multiplier_o <=
        prop_gain_q[loop_param_pkg::MULT_MSB:loop_param_pkg::MULT_LSB]; // RL5
      proportional_shift_o      <= prop_shift_d; // RL4
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      integral_multiplier_o <=
        loop_param_pkg::RST_INTEGRAL_GAIN[loop_param_pkg::MULT_MSB:loop_param_pkg::MULT_LSB];
      integral_shift_o      <= loop_param_pkg::SHIFT_DIV_64; // RL9
    end else begin
      integral_multiplier_o <=
        int_gain_q[loop_param_pkg::MULT_MSB:loop_param_pkg::MULT_LSB]; // RL7
      integral_shift_o      <= int_shift_d; // RL6
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      resistance_scale_factor_o <= loop_param_pkg::RES_SCALE_0;
    end else begin
      resistance_scale_factor_o <= scale_d; // RL10
    end
  end

  // A reserved code in either gain register stays flagged until software rewrites it.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      gain_code_reserved_o <= 1'b0;
    end else begin
      gain_code_reserved_o <= prop_reserved_field_d | int_reserved_field_d; // RL11
    end
  end

endmodule

`default_nettype wire

// ---- bench/loop_param_asserts.sv ----
// Port-level checker for the loop parameter register bank.
// Assumes it is bound to motor_loop_param_regs; one clock domain.
`timescale 1ns/1ns
`default_nettype none

module loop_param_asserts (
  input wire logic        core_clk_i,
  input wire logic        sys_rst_i,
  input wire logic        reg_wr_en_i,
  input wire logic [7:0]  reg_wr_addr_i,
  input wire logic [7:0]  reg_wr_data_i,
  input wire logic        reg_rd_en_i,
  input wire logic [7:0]  reg_rd_addr_i,
  input wire logic [1:0]  resistance_scale_sel_i,
  input wire logic [7:0]  reg_rd_data_o,
  input wire logic        reg_rd_hit_o,
  input wire logic [7:0]  inverse_coil_resistance_o,
  input wire logic [7:0]  back_emf_value_o,
  input wire logic [4:0]  proportional_multiplier_o,
  input wire logic [3:0]  proportional_shift_o,
  input wire logic [4:0]  integral_multiplier_o,
  input wire logic [3:0]  integral_shift_o,
  input wire logic [13:0] resistance_scale_factor_o,
  input wire logic        gain_code_reserved_o,
  input wire logic        inverse_resistance_zero_o
);
  logic       wp;
  logic       wi;
  logic [2:0] wcode;
  logic [4:0] wmult;
  assign wp = reg_wr_en_i && reg_wr_addr_i == 8'h18;
  assign wi = reg_wr_en_i && reg_wr_addr_i == 8'h19;
  assign wcode = reg_wr_data_i[7:5];
  assign wmult = reg_wr_data_i[4:0];

  // Code 7 has no divisor; the bank falls back to the largest shift.
  function automatic logic [3:0] shift_of(input logic [2:0] c);
    return (c == 3'h5) ? 4'h4 : (c == 3'h6) ? 4'h0 : (c == 3'h7) ? 4'h9 : 4'h5 + {1'b0, c};
  endfunction

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_inv_write:
    assert property (reg_wr_en_i && reg_wr_addr_i == 8'h14 |-> ##2
      inverse_coil_resistance_o == $past(reg_wr_data_i, 2)) else $error("inverse output wrong");
  chk_emf_write:
    assert property (reg_wr_en_i && reg_wr_addr_i == 8'h15 |-> ##2
      back_emf_value_o == $past(reg_wr_data_i, 2)) else $error("emf output wrong");
  chk_prop_gain:
    assert property (wp |-> ##2 proportional_shift_o == shift_of($past(wcode, 2))
      && proportional_multiplier_o == $past(wmult, 2)) else $error("proportional gain wrong");
  chk_int_gain:
    assert property (wi |-> ##2 integral_shift_o == shift_of($past(wcode, 2))
      && integral_multiplier_o == $past(wmult, 2)) else $error("integral gain wrong");
  chk_gain_reset:
    assert property ($fell(sys_rst_i) |-> proportional_multiplier_o == 5'h01
      && proportional_shift_o == 4'h6 && integral_multiplier_o == 5'h01
      && integral_shift_o == 4'h6) else $error("gain reset wrong");
  chk_code_reserved:
    assert property (wp && wcode == 3'h7 |-> ##2 gain_code_reserved_o)
      else $error("reserved code not flagged");
  chk_reserved_read:
    assert property (reg_rd_en_i && reg_rd_addr_i == 8'h16 |=> reg_rd_data_o == 8'h00
      && reg_rd_hit_o) else $error("reserved read wrong");
  chk_scale_map:
    assert property (1'b1 |=> resistance_scale_factor_o == ($past(resistance_scale_sel_i) == 2'h0
      ? 14'h0002 : $past(resistance_scale_sel_i) == 2'h1 ? 14'h0040
      : $past(resistance_scale_sel_i) == 2'h2 ? 14'h0400 : 14'h2000)) else $error("scale wrong");

  cover property (wp && wcode == 3'h7);
  cover property (reg_rd_en_i && reg_rd_addr_i == 8'h16);
  cover property ($fell(sys_rst_i));
endmodule

`default_nettype wire

// ---- bench/host_model.sv ----
// Host controller model issuing byte writes and reads to the bank.
// Assumes the bank takes requests on the rising edge; drives on falling.
`timescale 1ns/1ns
`default_nettype none

module host_model (
  input  wire logic       core_clk_i,
  input  wire logic [7:0] rd_data_i,
  input  wire logic       rd_hit_i,
  output logic            wr_en_o,
  output logic      [7:0] wr_addr_o,
  output logic      [7:0] wr_data_o,
  output logic            rd_en_o,
  output logic      [7:0] rd_addr_o
);
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    wr_addr_o = 8'h00;
    wr_data_o = 8'h00;
    rd_addr_o = 8'h00;
  end

  // Released lines carry the inverse so stale values never look valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    wr_en_o = 1'b1;
    wr_addr_o = a;
    wr_data_o = d;
    @(negedge core_clk_i);
    wr_en_o = 1'b0;
    wr_addr_o = ~a;
    wr_data_o = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(negedge core_clk_i);
    rd_en_o = 1'b1;
    rd_addr_o = a;
    @(negedge core_clk_i);
    rd_en_o = 1'b0;
    rd_addr_o = ~a;
    d = rd_data_i;
    h = rd_hit_i;
  endtask
endmodule

`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the loop parameter register bank.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic        clk = 1'b0, rst = 1'b1, wr_en, rd_en, rd_hit, rsv, zero;
  logic [7:0]  wr_addr, wr_data, rd_addr, rd_data, inverse_coil_resistance, emf;
  logic [1:0]  sel = 2'h0;
  logic [4:0]  p_mult, i_mult;
  logic [3:0]  p_shift, i_shift;
  logic [13:0] scale;
  int          miscompares = 0, comparisons = 0;

  always #2 clk = ~clk;

  host_model u_host (.core_clk_i(clk), .rd_data_i(rd_data), .rd_hit_i(rd_hit), .wr_en_o(wr_en),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data), .rd_en_o(rd_en), .rd_addr_o(rd_addr));

  motor_loop_param_regs u_dut (.core_clk_i(clk), .sys_rst_i(rst), .reg_wr_en_i(wr_en),
    .reg_wr_addr_i(wr_addr), .reg_wr_data_i(wr_data), .reg_rd_en_i(rd_en),
    .reg_rd_addr_i(rd_addr), .resistance_scale_sel_i(sel), .reg_rd_data_o(rd_data),
    .reg_rd_hit_o(rd_hit), .inverse_coil_resistance_o(inverse_coil_resistance), .back_emf_value_o(emf),
    .proportional_multiplier_o(p_mult), .proportional_shift_o(p_shift),
    .integral_multiplier_o(i_mult), .integral_shift_o(i_shift),
    .resistance_scale_factor_o(scale), .gain_code_reserved_o(rsv),
    .inverse_resistance_zero_o(zero));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
  endtask

  task automatic t_reset();
    logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h21, 8'h21};
    logic [7:0] d;
    logic       h;
    for (int i = 0; i < 6; i++) begin
      u_host.rd(8'h14 + i[7:0], d, h);
      check(d, rv[i], "reset value");
      check(h, 1'b1, "reset hit");
    end
    check({p_mult, p_shift}, {5'h01, 4'h6}, "reset p gain");
    check({i_mult, i_shift}, {5'h01, 4'h6}, "reset i gain");
    check(zero, 1'b1, "zero flag");
    $display("test reset done");
  endtask

  // Writes are one idle cycle apart; 0x16 and an unmapped offset must not stick.
  task automatic t_rw();
    logic [7:0] a [5] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h3c};
    logic [7:0] v [5] = '{8'h29, 8'ha5, 8'hff, 8'h5a, 8'h77};
    logic [7:0] e [5] = '{8'h29, 8'ha5, 8'h00, 8'h5a, 8'h00};
    logic [7:0] d;
    logic       h;
    for (int i = 0; i < 5; i++) u_host.wr(a[i], v[i]);
    for (int i = 0; i < 5; i++) begin
      u_host.rd(a[i], d, h);
      check(d, e[i], "read back");
      check(h, i < 4, "read hit");
    end
    check({inverse_coil_resistance, emf}, 16'h29a5, "loop values");
    check(zero, 1'b0, "zero flag");
    $display("test rw done");
  endtask

  task automatic t_gain();
    logic [3:0] shf [8] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'h4, 4'h0, 4'h9};
    logic [7:0] d;
    logic       h;
    logic [4:0] m, n;
    for (int c = 0; c < 8; c++) begin
      m = 5'(c * 3 + 1);
      n = ~m;
      u_host.wr(8'h18, {c[2:0], m});
      u_host.wr(8'h19, {c[2:0], n});
      @(negedge clk);
      check({p_shift, p_mult}, {shf[c], m}, "p gain");
      check({i_shift, i_mult}, {shf[c], n}, "i gain");
      check(rsv, c == 7, "reserved flag");
      u_host.rd(8'h18, d, h);
      check(d, {c[2:0], m}, "p read");
      u_host.rd(8'h19, d, h);
      check(d, {c[2:0], n}, "i read");
    end
    // Clear the proportional code first so the integral side of the flag is seen alone.
    u_host.wr(8'h18, 8'h21);
    @(negedge clk);
    check(rsv, 1'b1, "integral code flag");
    u_host.wr(8'h19, 8'h21);
    @(negedge clk);
    check(rsv, 1'b0, "flag cleared");
    $display("test gain done");
  endtask

  task automatic t_scale();
    logic [13:0] sc [4] = '{14'h0002, 14'h0040, 14'h0400, 14'h2000};
    for (int s = 0; s < 4; s++) begin
      sel = s[1:0];
      @(negedge clk);
      check(scale, sc[s], "scale");
    end
    $display("test scale done");
  endtask

  initial begin
    #8000;
    miscompares++;
    end_of_test();
  end

  initial begin
    do_reset();
    t_reset();
    t_rw();
    t_gain();
    t_scale();
    do_reset();
    t_reset();
    end_of_test();
  end
endmodule

bind motor_loop_param_regs loop_param_asserts u_chk (
  .core_clk_i                (core_clk_i),
  .sys_rst_i                 (sys_rst_i),
  .reg_wr_en_i               (reg_wr_en_i),
  .reg_wr_addr_i             (reg_wr_addr_i),
  .reg_wr_data_i             (reg_wr_data_i),
  .reg_rd_en_i               (reg_rd_en_i),
  .reg_rd_addr_i             (reg_rd_addr_i),
  .resistance_scale_sel_i    (resistance_scale_sel_i),
  .reg_rd_data_o             (reg_rd_data_o),
  .reg_rd_hit_o              (reg_rd_hit_o),
  .inverse_coil_resistance_o (inverse_coil_resistance_o),
  .back_emf_value_o          (back_emf_value_o),
  .proportional_multiplier_o (proportional_multiplier_o),
  .proportional_shift_o      (proportional_shift_o),
  .integral_multiplier_o     (integral_multiplier_o),
  .integral_shift_o          (integral_shift_o),
  .resistance_scale_factor_o (resistance_scale_factor_o),
  .gain_code_reserved_o      (gain_code_reserved_o),
  .inverse_resistance_zero_o (inverse_resistance_zero_o)
);

`default_nettype wire
